// ==== tb/pti_event_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module pti_event_src
    import pti_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire pti_event_t fire,
    output pti_event_t      evt
);
    // ---------------------------------------------------------------
    // match sources
    // ---------------------------------------------------------------
    // registered so every match is a clean copy of fire, one cycle later, quiet in reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt <= '0;
        end else begin
            evt <= fire;
        end
    end
endmodule : pti_event_src
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench import pti_pkg::*; ;
    logic                  aclk    = 1'b0;
    logic                  aresetn = 1'b0;
    logic [AXI_ADDR_W-1:0] awaddr  = '0, araddr = '0;
    logic [AXI_DATA_W-1:0] wdata   = '0, rdata, d;
    logic [AXI_STRB_W-1:0] wstrb   = 4'hf;
    logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                  awready, wready, bvalid, arready, rvalid, irq_any;
    logic [1:0]            bresp, rresp, r;
    logic [7:0]            addr, en, fl;
    pti_event_t            fire = '0, evt;
    pti_irq_t              irq;
    int                    err_count = 0, compares = 0, cycles = 0, i;

    pti_irq_flag_bank i_pti_irq_flag_bank (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .evt(evt), .irq(irq), .irq_any(irq_any));
    pti_event_src i_pti_event_src (.aclk(aclk), .aresetn(aresetn), .fire(fire), .evt(evt));

    initial forever #12.5 aclk = ~aclk;

    // ---------------------------------------------------------------
    // reporting
    // ---------------------------------------------------------------
    task conclude;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task chk_data(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data

    task chk_irq(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t irq got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_irq

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end

    // ---------------------------------------------------------------
    // bus access
    // ---------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= dv;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dv = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk_data(d, exp);
        chk_data({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : rd_chk

    // pulse lands two edges later; wait covers flag plus registered irq
    task pulse(input pti_event_t v);
        @(posedge aclk);
        fire <= v;
        @(posedge aclk);
        fire <= '0;
        repeat (4) @(posedge aclk);
    endtask : pulse

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h0c, 32'h0);
        chk_irq({irq_any, irq}, 9'h000);
        $display("test reset done");
        wr(8'h00, 32'hff, r);
        rd_chk(8'h00, 32'hff);
        wr(8'h04, 32'hff, r);
        rd_chk(8'h04, 32'h33);
        wr(8'h08, 32'hff, r);
        rd_chk(8'h08, 32'h33);
        wr(8'h00, 32'h0f, r);
        wr(8'h04, 32'h03, r);
        wr(8'h08, 32'h03, r);
        rd_chk(8'h00, 32'h0f);
        rd_chk(8'h04, 32'h03);
        rd_chk(8'h08, 32'h03);
        $display("test access done");
        // enables on, global off: flags set but nothing reaches the cpu
        pulse(8'hff);
        chk_irq({irq_any, irq}, 9'h000);
        rd_chk(8'h00, 32'hff);
        wr(8'h0c, 32'h01, r);
        repeat (3) @(posedge aclk);
        chk_irq({irq_any, irq}, 9'h1ff);
        wr(8'h00, 32'h0f, r);
        wr(8'h04, 32'h03, r);
        wr(8'h08, 32'h03, r);
        repeat (3) @(posedge aclk);
        chk_irq({irq_any, irq}, 9'h000);
        $display("test global gate done");
        for (i = 0; i < 8; i++) begin
            addr = (i >= 4) ? 8'h00 : (i >= 2) ? 8'h04 : 8'h08;
            en   = (i >= 4) ? 8'h0f : 8'h03;
            fl   = (i >= 4) ? (8'h01 << i) : (i % 2 == 1) ? 8'h20 : 8'h10;
            pulse(8'h01 << i);
            chk_irq({irq_any, irq}, {1'b1, 8'h01 << i});
            rd_chk(addr, {24'h0, en | fl});
            wr(addr, {24'h0, en}, r);
            rd_chk(addr, {24'h0, en});
        end
        $display("test per source done");
        // fired sources' enables off, global on: flags still set, nothing reaches the cpu
        wr(8'h00, 32'h07, r);
        wr(8'h04, 32'h01, r);
        wr(8'h08, 32'h02, r);
        pulse(8'h89);
        chk_irq({irq_any, irq}, 9'h000);
        rd_chk(8'h00, 32'h87);
        rd_chk(8'h04, 32'h21);
        rd_chk(8'h08, 32'h12);
        rd_chk(8'h0c, 32'h01);
        // lane 0 not strobed: write must leave the register alone
        wstrb <= 4'h0;
        wr(8'h00, 32'h00, r);
        wstrb <= 4'hf;
        chk_data({30'h0, r}, {30'h0, RESP_OKAY});
        rd_chk(8'h00, 32'h87);
        $display("test disabled sources done");
        rd(8'h10, d, r);
        chk_data({30'h0, r}, {30'h0, RESP_SLVERR});
        chk_data(d, 32'h0);
        wr(8'h10, 32'hff, r);
        chk_data({30'h0, r}, {30'h0, RESP_SLVERR});
        $display("test unmapped done");
        conclude();
    end
endmodule : testbench
`default_nettype wire

// ==== verilog/pti_flag_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
module pti_flag_reg
    import pti_pkg::*;
#(
    parameter logic [REG_W-1:0] FLAG_MASK   = PWM_FLAG_MASK,
    parameter logic [REG_W-1:0] ENABLE_MASK = PWM_ENABLE_MASK
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             wr_en,
    input  wire logic [REG_W-1:0] wr_data,
    input  wire logic [REG_W-1:0] set_req,
    output logic      [REG_W-1:0] value
);
    logic [REG_W-1:0] flags;
    logic [REG_W-1:0] enables;
    logic [REG_W-1:0] next_flags;

    // ---------------------------------------------------------------------
    // flags: software writes, hardware sets; set wins
    // ---------------------------------------------------------------------
    always_comb begin
        next_flags = ((wr_en ? wr_data : flags) | set_req) & FLAG_MASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags <= REG_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enables <= REG_RESET;
        end else if (wr_en) begin
            enables <= wr_data & ENABLE_MASK;
        end
    end

    assign value = flags | enables;

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    set_beats_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (set_req & FLAG_MASK) != '0 |=> (value & $past(set_req) & FLAG_MASK) == ($past(set_req) & FLAG_MASK))
        else $error("hardware set lost against a write");
    flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_en |=> (value & FLAG_MASK & $past(flags)) == $past(flags))
        else $error("flag cleared without a software write");
    unimpl_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (value & ~(FLAG_MASK | ENABLE_MASK)) == '0)
        else $error("unimplemented bit reads as one");
endmodule : pti_flag_reg
`default_nettype wire

// ==== verilog/pti_irq_flag_bank.sv ====
// Summary of operation
// - pwm period match sets bit 7 of the pwm register
// - pwm channel 2, 1, 0 duty matches set bits 6, 5, 4
// - bit 3 enables the period match interrupt
// - bits 2, 1, 0 enable the channel 2, 1, 0 duty interrupts
// - flags stay set until software writes zero; writing zero clears them
// - timer 2 comparator A sets bit 5, comparator P sets bit 4
// - timer 2 bit 1 enables comparator A, bit 0 comparator P
// - timer 0 comparator A sets bit 5, comparator P sets bit 4
// - timer 0 bit 1 enables comparator A, bit 0 comparator P
// - timer register bits 7-6 and 3-2 read zero, ignore writes
// - flags set regardless of enable; irq needs enable and global enable
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pti_irq_flag_bank
    import pti_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [AXI_DATA_W-1:0] wdata,
    input  wire logic [AXI_STRB_W-1:0] wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic      [1:0]            bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic      [AXI_DATA_W-1:0] rdata,
    output logic      [1:0]            rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire pti_event_t            evt,
    output pti_irq_t                   irq,
    output logic                       irq_any
);
    // ---------------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------------
    function automatic pti_sel_t decode_sel(input logic [AXI_ADDR_W-1:0] addr);
        logic [AXI_ADDR_W-1:WORD_LSB] word;
        word = addr[AXI_ADDR_W-1:WORD_LSB];
        if (word == PWM_IRQ_FLAGS_ENABLES_OFFSET[AXI_ADDR_W-1:WORD_LSB]) begin
            return SEL_PWM;
        end else if (word == TIMER2_IRQ_FLAGS_ENABLES_OFFSET[AXI_ADDR_W-1:WORD_LSB]) begin
            return SEL_TIMER2;
        end else if (word == TIMER0_IRQ_FLAGS_ENABLES_OFFSET[AXI_ADDR_W-1:WORD_LSB]) begin
            return SEL_TIMER0;
        end else if (word == GLOBAL_IRQ_CTRL_OFFSET[AXI_ADDR_W-1:WORD_LSB]) begin
            return SEL_CTRL;
        end
        return SEL_NONE;
    endfunction : decode_sel

    logic                                aw_held;
    logic                                w_held;
    logic [AXI_ADDR_W-1:0]               aw_addr_q;
    logic [REG_W-1:0]                    w_data_q;
    logic                                w_lane0_q;
    logic                                wr_fire;
    pti_sel_t                            wr_sel;
    pti_sel_t                            rd_sel;
    logic [NUM_BANKS-1:0]                bank_wr;
    logic                                ctrl_wr;
    logic [NUM_BANKS-1:0][REG_W-1:0]     set_vec;
    logic [NUM_BANKS-1:0][REG_W-1:0]     bank_val;
    logic                                global_irq_enable;
    logic [REG_W-1:0]                    rd_word;
    pti_irq_t                            next_irq;

    // ---------------------------------------------------------------------
    // write channels: address and data taken in either order
    // ---------------------------------------------------------------------
    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_sel  = decode_sel(aw_addr_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_held   <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_held   <= 1'b0;
        end
    end

    // only lane 0 carries register bits; upper lanes are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held    <= 1'b0;
            w_data_q  <= '0;
            w_lane0_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_held    <= 1'b1;
            w_data_q  <= wdata[REG_W-1:0];
            w_lane0_q <= wstrb[0];
        end else if (wr_fire) begin
            w_held    <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_comb begin
        bank_wr = '0;
        ctrl_wr = 1'b0;
        unique case (wr_sel)
            SEL_PWM:    bank_wr[BANK_PWM]    = wr_fire && w_lane0_q;
            SEL_TIMER2: bank_wr[BANK_TIMER2] = wr_fire && w_lane0_q;
            SEL_TIMER0: bank_wr[BANK_TIMER0] = wr_fire && w_lane0_q;
            SEL_CTRL:   ctrl_wr              = wr_fire && w_lane0_q;
            SEL_NONE:   ctrl_wr              = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            global_irq_enable <= 1'b0;
        end else if (ctrl_wr) begin
            global_irq_enable <= w_data_q[GLOBAL_IRQ_ENABLE_BIT];
        end
    end

    // ---------------------------------------------------------------------
    // read channel: one cycle to answer
    // ---------------------------------------------------------------------
    assign arready = !rvalid;
    assign rd_sel  = decode_sel(araddr);

    always_comb begin
        rd_word = '0;
        unique case (rd_sel)
            SEL_PWM:    rd_word = bank_val[BANK_PWM];
            SEL_TIMER2: rd_word = bank_val[BANK_TIMER2];
            SEL_TIMER0: rd_word = bank_val[BANK_TIMER0];
            SEL_CTRL:   rd_word[GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable;
            SEL_NONE:   rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {{(AXI_DATA_W-REG_W){1'b0}}, rd_word};
            rresp  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ---------------------------------------------------------------------
    // event routing into flag positions
    // ---------------------------------------------------------------------
    always_comb begin
        set_vec = '0;
        set_vec[BANK_PWM][PERIOD_MATCH_REQUEST_BIT]     = evt.period_match;
        set_vec[BANK_PWM][CHAN2_DUTY_MATCH_REQUEST_BIT] = evt.chan2_duty_match;
        set_vec[BANK_PWM][CHAN1_DUTY_MATCH_REQUEST_BIT] = evt.chan1_duty_match;
        set_vec[BANK_PWM][CHAN0_DUTY_MATCH_REQUEST_BIT] = evt.chan0_duty_match;
        set_vec[BANK_TIMER2][TIMER_CMP_A_REQUEST_BIT]   = evt.timer2_cmp_a;
        set_vec[BANK_TIMER2][TIMER_CMP_P_REQUEST_BIT]   = evt.timer2_cmp_p;
        set_vec[BANK_TIMER0][TIMER_CMP_A_REQUEST_BIT]   = evt.timer0_cmp_a;
        set_vec[BANK_TIMER0][TIMER_CMP_P_REQUEST_BIT]   = evt.timer0_cmp_p;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
            pti_flag_reg #(
                .FLAG_MASK   (BANK_FLAG_MASK[gi]),
                .ENABLE_MASK (BANK_ENABLE_MASK[gi])
            ) u_reg (
                .aclk    (aclk),
                .aresetn (aresetn),
                .wr_en   (bank_wr[gi]),
                .wr_data (w_data_q),
                .set_req (set_vec[gi]),
                .value   (bank_val[gi])
            );
        end
    endgenerate

    // ---------------------------------------------------------------------
    // request gating toward the cpu; registered to keep outputs glitch-free
    // ---------------------------------------------------------------------
    always_comb begin
        next_irq.period_match     = bank_val[BANK_PWM][PERIOD_MATCH_REQUEST_BIT]
                                  & bank_val[BANK_PWM][PERIOD_MATCH_IRQ_ENABLE_BIT] & global_irq_enable;
        next_irq.chan2_duty_match = bank_val[BANK_PWM][CHAN2_DUTY_MATCH_REQUEST_BIT]
                                  & bank_val[BANK_PWM][CHAN2_DUTY_IRQ_ENABLE_BIT] & global_irq_enable;
        next_irq.chan1_duty_match = bank_val[BANK_PWM][CHAN1_DUTY_MATCH_REQUEST_BIT]
                                  & bank_val[BANK_PWM][CHAN1_DUTY_IRQ_ENABLE_BIT] & global_irq_enable;
        next_irq.chan0_duty_match = bank_val[BANK_PWM][CHAN0_DUTY_MATCH_REQUEST_BIT]
                                  & bank_val[BANK_PWM][CHAN0_DUTY_IRQ_ENABLE_BIT] & global_irq_enable;
        next_irq.timer2_cmp_a     = bank_val[BANK_TIMER2][TIMER_CMP_A_REQUEST_BIT]
                                  & bank_val[BANK_TIMER2][TIMER_CMP_A_IRQ_ENABLE_BIT] & global_irq_enable;
        next_irq.timer2_cmp_p     = bank_val[BANK_TIMER2][TIMER_CMP_P_REQUEST_BIT]
                                  & bank_val[BANK_TIMER2][TIMER_CMP_P_IRQ_ENABLE_BIT] & global_irq_enable;
        next_irq.timer0_cmp_a     = bank_val[BANK_TIMER0][TIMER_CMP_A_REQUEST_BIT]
                                  & bank_val[BANK_TIMER0][TIMER_CMP_A_IRQ_ENABLE_BIT] & global_irq_enable;
        next_irq.timer0_cmp_p     = bank_val[BANK_TIMER0][TIMER_CMP_P_REQUEST_BIT]
                                  & bank_val[BANK_TIMER0][TIMER_CMP_P_IRQ_ENABLE_BIT] & global_irq_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq     <= '0;
            irq_any <= 1'b0;
        end else begin
            irq     <= next_irq;
            irq_any <= |next_irq;
        end
    end

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    period_flag_set_a: assert property (evt.period_match |=>
        bank_val[BANK_PWM][PERIOD_MATCH_REQUEST_BIT] ##1
        (bank_val[BANK_PWM][PERIOD_MATCH_REQUEST_BIT] || $past(bank_wr[BANK_PWM])))
        else $error("period match flag not set");
    duty_flags_set_a: assert property (evt.chan2_duty_match && evt.chan0_duty_match |=>
        bank_val[BANK_PWM][CHAN2_DUTY_MATCH_REQUEST_BIT] && bank_val[BANK_PWM][CHAN0_DUTY_MATCH_REQUEST_BIT])
        else $error("duty match flags not set");
    period_gate_a: assert property (evt.period_match && !bank_val[BANK_PWM][PERIOD_MATCH_IRQ_ENABLE_BIT]
        && !bank_wr[BANK_PWM] |=> !irq.period_match)
        else $error("period irq raised while disabled");
    duty_gate_a: assert property ($rose(irq.chan1_duty_match) |->
        $past(bank_val[BANK_PWM][CHAN1_DUTY_IRQ_ENABLE_BIT]) && $past(bank_val[BANK_PWM][CHAN1_DUTY_MATCH_REQUEST_BIT]))
        else $error("channel 1 duty irq without flag and enable");
    write_clear_a: assert property (bank_wr[BANK_PWM] && !w_data_q[PERIOD_MATCH_REQUEST_BIT]
        && !set_vec[BANK_PWM][PERIOD_MATCH_REQUEST_BIT] |=>
        !bank_val[BANK_PWM][PERIOD_MATCH_REQUEST_BIT] ##1 !irq.period_match)
        else $error("software zero write did not clear");
    timer2_set_a: assert property (evt.timer2_cmp_a && evt.timer2_cmp_p |=>
        bank_val[BANK_TIMER2][TIMER_CMP_A_REQUEST_BIT] && bank_val[BANK_TIMER2][TIMER_CMP_P_REQUEST_BIT])
        else $error("timer 2 flags not set");
    timer2_irq_a: assert property (bank_val[BANK_TIMER2][TIMER_CMP_P_REQUEST_BIT]
        && bank_val[BANK_TIMER2][TIMER_CMP_P_IRQ_ENABLE_BIT] && global_irq_enable |=> irq.timer2_cmp_p && irq_any)
        else $error("timer 2 comparator P irq missing");
    timer0_set_a: assert property (evt.timer0_cmp_p |=> bank_val[BANK_TIMER0][TIMER_CMP_P_REQUEST_BIT])
        else $error("timer 0 comparator P flag not set");
    timer0_irq_a: assert property (bank_val[BANK_TIMER0][TIMER_CMP_A_REQUEST_BIT]
        && bank_val[BANK_TIMER0][TIMER_CMP_A_IRQ_ENABLE_BIT] && global_irq_enable |=> irq.timer0_cmp_a)
        else $error("timer 0 comparator A irq missing");
    timer_reserved_a: assert property (rvalid && $past(arvalid && arready && rd_sel == SEL_TIMER0) |->
        (rdata[REG_W-1:0] & ~TMR_FLAG_MASK & ~TMR_ENABLE_MASK) == '0)
        else $error("timer reserved bits read nonzero");
    timer2_gate_a: assert property (bank_val[BANK_TIMER2][TIMER_CMP_A_REQUEST_BIT]
        && !bank_val[BANK_TIMER2][TIMER_CMP_A_IRQ_ENABLE_BIT] |=> !irq.timer2_cmp_a)
        else $error("timer 2 comparator A irq while disabled");
    timer0_gate_a: assert property (bank_val[BANK_TIMER0][TIMER_CMP_P_REQUEST_BIT]
        && !bank_val[BANK_TIMER0][TIMER_CMP_P_IRQ_ENABLE_BIT] |=> !irq.timer0_cmp_p)
        else $error("timer 0 comparator P irq while disabled");
    ctrl_read_a: assert property (arvalid && arready && rd_sel == SEL_CTRL |=>
        rdata == {{(AXI_DATA_W-1){1'b0}}, $past(global_irq_enable)})
        else $error("global enable read back wrong");
    global_off_a: assert property (!global_irq_enable |=> !irq_any)
        else $error("irq raised with global enable off");
    reset_clear_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
        bank_val == '0 && !global_irq_enable && !irq_any)
        else $error("reset did not clear the registers");

    // ---------------------------------------------------------------------
    // checks: register bus
    // ---------------------------------------------------------------------
    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    bresp_error_a: assert property (wr_fire && wr_sel == SEL_NONE |=> bvalid && bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    period_irq_c: cover property (evt.period_match ##2 irq.period_match);
    timer0_irq_c: cover property (evt.timer0_cmp_a ##2 irq.timer0_cmp_a);
    write_c: cover property (awvalid && awready && wvalid && wready ##[1:4] bvalid && bready);
    read_c: cover property (arvalid && arready ##1 rvalid && rready);
    gated_c: cover property (evt.period_match && !bank_val[BANK_PWM][PERIOD_MATCH_IRQ_ENABLE_BIT] && global_irq_enable);
endmodule : pti_irq_flag_bank
`default_nettype wire

// ==== verilog/pti_pkg.sv ====
`default_nettype none
package pti_pkg;
    // ---------------------------------------------------------------------
    // bus and register geometry
    // ---------------------------------------------------------------------
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int AXI_STRB_W = AXI_DATA_W / 8;
    localparam int REG_W      = 8;
    localparam int NUM_BANKS  = 3;
    localparam int WORD_LSB   = 2;

    localparam logic [AXI_ADDR_W-1:0] PWM_IRQ_FLAGS_ENABLES_OFFSET    = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] TIMER2_IRQ_FLAGS_ENABLES_OFFSET = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] TIMER0_IRQ_FLAGS_ENABLES_OFFSET = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] GLOBAL_IRQ_CTRL_OFFSET          = 8'h0c;

    localparam int BANK_PWM    = 0;
    localparam int BANK_TIMER2 = 1;
    localparam int BANK_TIMER0 = 2;

    // ---------------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------------
    localparam int PERIOD_MATCH_REQUEST_BIT     = 7;
    localparam int CHAN2_DUTY_MATCH_REQUEST_BIT = 6;
    localparam int CHAN1_DUTY_MATCH_REQUEST_BIT = 5;
    localparam int CHAN0_DUTY_MATCH_REQUEST_BIT = 4;
    localparam int PERIOD_MATCH_IRQ_ENABLE_BIT  = 3;
    localparam int CHAN2_DUTY_IRQ_ENABLE_BIT    = 2;
    localparam int CHAN1_DUTY_IRQ_ENABLE_BIT    = 1;
    localparam int CHAN0_DUTY_IRQ_ENABLE_BIT    = 0;
    localparam int TIMER_CMP_A_REQUEST_BIT      = 5;
    localparam int TIMER_CMP_P_REQUEST_BIT      = 4;
    localparam int TIMER_CMP_A_IRQ_ENABLE_BIT   = 1;
    localparam int TIMER_CMP_P_IRQ_ENABLE_BIT   = 0;
    localparam int GLOBAL_IRQ_ENABLE_BIT        = 0;

    localparam logic [REG_W-1:0] REG_RESET        = 8'h00;
    localparam logic [REG_W-1:0] PWM_FLAG_MASK    = 8'hf0;
    localparam logic [REG_W-1:0] PWM_ENABLE_MASK  = 8'h0f;
    localparam logic [REG_W-1:0] TMR_FLAG_MASK    = 8'h30;
    localparam logic [REG_W-1:0] TMR_ENABLE_MASK  = 8'h03;
    localparam logic [NUM_BANKS-1:0][REG_W-1:0] BANK_FLAG_MASK   = {TMR_FLAG_MASK, TMR_FLAG_MASK, PWM_FLAG_MASK};
    localparam logic [NUM_BANKS-1:0][REG_W-1:0] BANK_ENABLE_MASK = {TMR_ENABLE_MASK, TMR_ENABLE_MASK,
                                                                    PWM_ENABLE_MASK};

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ---------------------------------------------------------------------
    // types
    // ---------------------------------------------------------------------
    typedef struct packed {
        logic period_match;
        logic chan2_duty_match;
        logic chan1_duty_match;
        logic chan0_duty_match;
        logic timer2_cmp_a;
        logic timer2_cmp_p;
        logic timer0_cmp_a;
        logic timer0_cmp_p;
    } pti_event_t;

    typedef struct packed {
        logic period_match;
        logic chan2_duty_match;
        logic chan1_duty_match;
        logic chan0_duty_match;
        logic timer2_cmp_a;
        logic timer2_cmp_p;
        logic timer0_cmp_a;
        logic timer0_cmp_p;
    } pti_irq_t;

    typedef enum logic [2:0] {SEL_PWM, SEL_TIMER2, SEL_TIMER0, SEL_CTRL, SEL_NONE} pti_sel_t;
endpackage : pti_pkg
`default_nettype wire
